// [rtl/cgd_pkg.sv]
// package for the clock gating and divider control block
package cgd_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int CGD_ADDR_W = 32;
    localparam int CGD_DATA_W = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [31:0] BUS_DIV_ADDR = 32'h5000_0000;
    localparam logic [31:0] TRIM_ADDR = 32'h5000_0002;
    localparam logic [31:0] GATES_ADDR = 32'h5000_0004;
    localparam logic [31:0] RADIO_ADDR = 32'h5000_0008;
    localparam logic [31:0] SRC_SEL_ADDR = 32'h5000_000A;

    // ----------------------------------------------------------------
    // writable bits of each register, reserved bits stay zero
    // ----------------------------------------------------------------
    localparam logic [15:0] BUS_DIV_WMASK = 16'h00B3;
    localparam logic [15:0] TRIM_WMASK = 16'h07FF;
    localparam logic [15:0] GATES_WMASK = 16'h8BFB;
    localparam logic [15:0] RADIO_WMASK = 16'h00FB;
    localparam logic [15:0] SRC_SEL_WMASK = 16'h0003;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [15:0] BUS_DIV_RST = 16'h0022;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam logic [15:0] GATES_RST = 16'h0000;
    localparam logic [15:0] RADIO_RST = 16'h0040;
    localparam logic [15:0] SRC_SEL_RST = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int AHB_DIV_LSB = 0;
    localparam int APB_DIV_LSB = 4;
    localparam int OTP_GATE_BIT = 7;
    localparam int FINE_TRIM_LSB = 0;
    localparam int COARSE_TRIM_LSB = 8;
    localparam int FIRST_TIMER_DIV_LSB = 0;
    localparam int TIMERS_GATE_BIT = 3;
    localparam int WAKE_GATE_BIT = 4;
    localparam int I2C_GATE_BIT = 5;
    localparam int SECOND_UART_GATE_BIT = 6;
    localparam int FIRST_UART_GATE_BIT = 7;
    localparam int SPI_DIV_LSB = 8;
    localparam int SPI_GATE_BIT = 11;
    localparam int QUAD_GATE_BIT = 15;
    localparam int RF_CONTROL_UNIT_DIVIDER_LSB = 0;
    localparam int RFCU_GATE_BIT = 3;
    localparam int BASEBAND_DIV_LSB = 4;
    localparam int LP_RESET_BIT = 6;
    localparam int BASEBAND_GATE_BIT = 7;
    localparam int SRC_SEL_LSB = 0;
    localparam int RUN_32K_BIT = 5;
    localparam int RUN_RC_BIT = 6;
    localparam int RUN_XTAL_BIT = 7;

    // ----------------------------------------------------------------
    // source select codes and peripheral channel indices
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_XTAL16 = 2'h0;
    localparam logic [1:0] SRC_RC16 = 2'h1;

    localparam int CH_OTP = 0;
    localparam int CH_QUAD = 1;
    localparam int CH_SPI = 2;
    localparam int CH_UART1 = 3;
    localparam int CH_UART2 = 4;
    localparam int CH_I2C = 5;
    localparam int CH_WAKE = 6;
    localparam int CH_FIRST_GENERAL_TIMER = 7;
    localparam int CH_THIRD_GENERAL_TIMER = 8;
    localparam int CH_BASEBAND = 9;
    localparam int CH_RFCU = 10;
    localparam int CGD_NUM_CH = 11;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [CGD_ADDR_W-1:0] addr;
        logic [CGD_DATA_W-1:0] wdata;
    } cgd_bus_req_type;

    typedef struct packed {
        logic [15:0] bus_div;
        logic [15:0] trim;
        logic [15:0] gates;
        logic [15:0] radio;
        logic [15:0] src_sel;
    } cgd_regs_type;

    // divide by 1,2,4,8 -> counter wraps at 0,1,3,7
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

endpackage

// [rtl/cgd_div_gate.sv]
// gated power-of-two divider working on enable pulses
`timescale 1ns/1ps
module cgd_div_gate
    import cgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick_in,
    input wire logic gate,
    input wire logic [1:0] div_code,
    output logic tick_out
);

    typedef struct packed {
        logic [2:0] cnt;
        logic [1:0] code;
        logic tick;
    } cgd_div_state_type;

    cgd_div_state_type state_r;
    cgd_div_state_type state_nxt;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // gate and ratio are sampled only when the count is at zero, so a
    // change never cuts a divided period short
    always_comb begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (tick_in) begin
            if (state_r.cnt == 3'h0) begin
                state_nxt.code = div_code;
                state_nxt.tick = gate;
                state_nxt.cnt = 3'h1 & div_mask(div_code);
            end else begin
                state_nxt.tick = 1'b0;
                state_nxt.cnt = (state_r.cnt + 3'h1) & div_mask(state_r.code);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tick_out = state_r.tick;

endmodule

// [rtl/cgd_clock_control.sv]
// clock gating, divider and crystal trim control with register port
//
// Notes on behaviour
// - otp controller clock runs only while its enable bit 7 is set; resets off.
// - bus and processor clock is source divided by 1,2,4,8; resets to divide-by-4.
// - peripheral bus clock further divides the bus clock by 1,2,4,8; resets code 2.
// - three-bit coarse crystal trim at bits 10:8, zero slowest, seven fastest.
// - eight-bit fine crystal trim at bits 7:0, zero slowest; resets zero.
// - quadrature decoder clock runs only while bit 15 is set; resets off.
// - spi clock gated by bit 11, divided by bits 9:8; both reset zero.
// - separate enables for both uarts, i2c and wakeup capture timer; reset off.
// - bit 3 gates first and third general timers together; resets off.
// - first general timer clock divided by 1,2,4,8 from bits 1:0.
// - baseband core clocks run only while radio bit 7 is set; reset off.
// - baseband low-power timer held in reset while radio bit 6 set; resets set.
// - baseband core clock divided by 1,2,4,8 from radio bits 5:4.
// - rf control unit clock gated by radio bit 3; resets off.
// - two-bit source select: crystal, rc oscillator, or 32 kHz source.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module cgd_clock_control
    import cgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input cgd_bus_req_type bus_req,
    output logic [CGD_DATA_W-1:0] rd_data,
    input wire logic slow_clk_pin,
    output logic [1:0] source_clock_select,
    output logic ahb_clk_en,
    output logic apb_clk_en,
    output logic [CGD_NUM_CH-1:0] periph_clk_en,
    output logic [2:0] crystal_coarse_trim,
    output logic [7:0] crystal_fine_trim,
    output logic baseband_lowpower_timer_reset
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cgd_regs_type regs;
        logic [2:0] slow_sync;
        logic src_tick;
        logic [CGD_DATA_W-1:0] rd_data;
    } cgd_top_state_type;

    cgd_top_state_type state_r;
    cgd_top_state_type state_nxt;

    logic ahb_tick;
    logic apb_tick;
    logic [CGD_NUM_CH-1:0] ch_base;
    logic [CGD_NUM_CH-1:0] ch_gate;
    logic [1:0] ch_code [CGD_NUM_CH];
    logic [1:0] sel_now;

    assign sel_now = state_r.regs.src_sel[SRC_SEL_LSB +: 2];

    // ----------------------------------------------------------------
    // register port and source tick
    // ----------------------------------------------------------------
    // ref_clk stands for either 16 MHz source; the 32 kHz source comes
    // in on a pin, so it is synchronised and only its rising edge is used
    always_comb begin
        state_nxt = state_r;
        state_nxt.slow_sync = {state_r.slow_sync[1:0], slow_clk_pin};
        if (sel_now == SRC_XTAL16 || sel_now == SRC_RC16) begin
            state_nxt.src_tick = 1'b1;
        end else begin
            state_nxt.src_tick = state_r.slow_sync[1] & ~state_r.slow_sync[2];
        end

        if (bus_req.wr_stb) begin
            unique case (bus_req.addr)
                BUS_DIV_ADDR: begin
                    state_nxt.regs.bus_div = bus_req.wdata & BUS_DIV_WMASK;
                end
                TRIM_ADDR: begin
                    state_nxt.regs.trim = bus_req.wdata & TRIM_WMASK;
                end
                GATES_ADDR: begin
                    state_nxt.regs.gates = bus_req.wdata & GATES_WMASK;
                end
                RADIO_ADDR: begin
                    state_nxt.regs.radio = bus_req.wdata & RADIO_WMASK;
                end
                SRC_SEL_ADDR: begin
                    state_nxt.regs.src_sel = bus_req.wdata & SRC_SEL_WMASK;
                end
                default: begin
                    state_nxt.regs = state_r.regs;
                end
            endcase
        end

        // read data stand for exactly one cycle after the strobe
        state_nxt.rd_data = '0;
        if (bus_req.rd_stb) begin
            unique case (bus_req.addr)
                BUS_DIV_ADDR: begin
                    state_nxt.rd_data = state_r.regs.bus_div;
                end
                TRIM_ADDR: begin
                    state_nxt.rd_data = state_r.regs.trim;
                end
                GATES_ADDR: begin
                    state_nxt.rd_data = state_r.regs.gates;
                end
                RADIO_ADDR: begin
                    state_nxt.rd_data = state_r.regs.radio;
                end
                SRC_SEL_ADDR: begin
                    state_nxt.rd_data = state_r.regs.src_sel;
                    state_nxt.rd_data[RUN_XTAL_BIT] = (sel_now == SRC_XTAL16);
                    state_nxt.rd_data[RUN_RC_BIT] = (sel_now == SRC_RC16);
                    state_nxt.rd_data[RUN_32K_BIT] = sel_now[1];
                end
                default: begin
                    state_nxt.rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r.regs.bus_div <= BUS_DIV_RST;
            state_r.regs.trim <= TRIM_RST;
            state_r.regs.gates <= GATES_RST;
            state_r.regs.radio <= RADIO_RST;
            state_r.regs.src_sel <= SRC_SEL_RST;
            state_r.slow_sync <= 3'h0;
            state_r.src_tick <= 1'b0;
            state_r.rd_data <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // bus clock chain
    // ----------------------------------------------------------------
    cgd_div_gate u_ahb_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick_in(state_r.src_tick),
        .gate(1'b1),
        .div_code(state_r.regs.bus_div[AHB_DIV_LSB +: 2]),
        .tick_out(ahb_tick)
    );

    // cascaded behind the bus clock, so it can never outrun it
    cgd_div_gate u_apb_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick_in(ahb_tick),
        .gate(1'b1),
        .div_code(state_r.regs.bus_div[APB_DIV_LSB +: 2]),
        .tick_out(apb_tick)
    );

    // ----------------------------------------------------------------
    // peripheral channel wiring
    // ----------------------------------------------------------------
    always_comb begin
        ch_base = {CGD_NUM_CH{apb_tick}};
        ch_base[CH_OTP] = ahb_tick;
        ch_base[CH_BASEBAND] = ahb_tick;
        // the rf unit divides the source directly; software picks the ratio
        ch_base[CH_RFCU] = state_r.src_tick;

        ch_gate[CH_OTP] = state_r.regs.bus_div[OTP_GATE_BIT];
        ch_gate[CH_QUAD] = state_r.regs.gates[QUAD_GATE_BIT];
        ch_gate[CH_SPI] = state_r.regs.gates[SPI_GATE_BIT];
        ch_gate[CH_UART1] = state_r.regs.gates[FIRST_UART_GATE_BIT];
        ch_gate[CH_UART2] = state_r.regs.gates[SECOND_UART_GATE_BIT];
        ch_gate[CH_I2C] = state_r.regs.gates[I2C_GATE_BIT];
        ch_gate[CH_WAKE] = state_r.regs.gates[WAKE_GATE_BIT];
        ch_gate[CH_FIRST_GENERAL_TIMER] = state_r.regs.gates[TIMERS_GATE_BIT];
        ch_gate[CH_THIRD_GENERAL_TIMER] = state_r.regs.gates[TIMERS_GATE_BIT];
        ch_gate[CH_BASEBAND] = state_r.regs.radio[BASEBAND_GATE_BIT];
        ch_gate[CH_RFCU] = state_r.regs.radio[RFCU_GATE_BIT];

        for (int i = 0; i < CGD_NUM_CH; i++) begin
            ch_code[i] = 2'h0;
        end
        ch_code[CH_SPI] = state_r.regs.gates[SPI_DIV_LSB +: 2];
        ch_code[CH_FIRST_GENERAL_TIMER] = state_r.regs.gates[FIRST_TIMER_DIV_LSB +: 2];
        // ratio is not range checked: staying at or above half the cpu clock is up to software
        ch_code[CH_BASEBAND] = state_r.regs.radio[BASEBAND_DIV_LSB +: 2];
        ch_code[CH_RFCU] = state_r.regs.radio[RF_CONTROL_UNIT_DIVIDER_LSB +: 2];
    end

    // ----------------------------------------------------------------
    // per-channel gate and divider
    // ----------------------------------------------------------------
    for (genvar g = 0; g < CGD_NUM_CH; g++) begin : gen_ch
        cgd_div_gate u_ch (
            .ref_clk(ref_clk),
            .reset(reset),
            .tick_in(ch_base[g]),
            .gate(ch_gate[g]),
            .div_code(ch_code[g]),
            .tick_out(periph_clk_en[g])
        );
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // trim steps are passed through as written; pacing a coarse step
    // and its settle time is left to software
    assign crystal_coarse_trim = state_r.regs.trim[COARSE_TRIM_LSB +: 3];
    assign crystal_fine_trim = state_r.regs.trim[FINE_TRIM_LSB +: 8];
    assign baseband_lowpower_timer_reset = state_r.regs.radio[LP_RESET_BIT];
    assign source_clock_select = sel_now;
    assign ahb_clk_en = ahb_tick;
    assign apb_clk_en = apb_tick;
    assign rd_data = state_r.rd_data;

endmodule

// [sim/cgd_clock_control_properties.sv]
// assertion checker for the clock gating and divider control block
`timescale 1ns/1ps
module cgd_clock_control_checker
    import cgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input cgd_bus_req_type bus_req,
    input wire logic [CGD_DATA_W-1:0] rd_data,
    input wire logic [1:0] source_clock_select,
    input wire logic [CGD_NUM_CH-1:0] periph_clk_en,
    input wire logic [2:0] crystal_coarse_trim,
    input wire logic [7:0] crystal_fine_trim,
    input wire logic baseband_lowpower_timer_reset
);
    // ----------------------------------------------------------------
    // shadow of the gate registers: a pulse needs its gate set at launch
    // ----------------------------------------------------------------
    logic [15:0] bus_seen_r;
    logic [15:0] gates_seen_r;
    logic [15:0] radio_seen_r;
    logic mapped;
    logic wr_trim;
    logic wr_radio;
    logic wr_src;
    assign mapped = bus_req.addr inside {BUS_DIV_ADDR, TRIM_ADDR, GATES_ADDR, RADIO_ADDR, SRC_SEL_ADDR};
    assign wr_trim = bus_req.wr_stb && bus_req.addr == TRIM_ADDR;
    assign wr_radio = bus_req.wr_stb && bus_req.addr == RADIO_ADDR;
    assign wr_src = bus_req.wr_stb && bus_req.addr == SRC_SEL_ADDR;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_seen_r <= 16'h0000;
            gates_seen_r <= 16'h0000;
            radio_seen_r <= 16'h0000;
        end else begin
            bus_seen_r <= (bus_req.wr_stb && bus_req.addr == BUS_DIV_ADDR) ? bus_req.wdata : bus_seen_r;
            gates_seen_r <= (bus_req.wr_stb && bus_req.addr == GATES_ADDR) ? bus_req.wdata : gates_seen_r;
            radio_seen_r <= wr_radio ? bus_req.wdata : radio_seen_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_rd_unmapped;
        bus_req.rd_stb && !mapped;
    endsequence
    sequence s_quiet;
        ##1 !bus_req.wr_stb;
    endsequence
    property p_trim_lands;
        logic [15:0] v;
        (wr_trim, v = bus_req.wdata) ##0 s_quiet |-> ##[0:1] {crystal_coarse_trim, crystal_fine_trim} == v[10:0];
    endproperty
    property p_lp_lands;
        logic [15:0] v;
        (wr_radio, v = bus_req.wdata) ##0 s_quiet |-> ##[0:1] baseband_lowpower_timer_reset == v[6];
    endproperty
    property p_src_lands;
        logic [15:0] v;
        (wr_src, v = bus_req.wdata) ##0 s_quiet |-> ##[0:1] source_clock_select == v[1:0];
    endproperty

    a_trim_follows_write: assert property (p_trim_lands) else $error("trim outputs differ from write");
    a_lp_follows_write: assert property (p_lp_lands) else $error("lp reset differs from write");
    a_src_follows_write: assert property (p_src_lands) else $error("source select differs from write");
    a_reset_defaults: assert property ($fell(reset) |-> baseband_lowpower_timer_reset
        && crystal_fine_trim == 8'h00 && crystal_coarse_trim == 3'h0 && source_clock_select == 2'h0)
        else $error("bad levels after reset");
    a_unmapped_reads_zero: assert property (s_rd_unmapped |=> rd_data == 16'h0000) else $error("hole read nonzero");
    // a pulse seen at an edge was launched from the gate of the edge before
    a_otp_needs_gate: assert property (periph_clk_en[CH_OTP] |-> $past(bus_seen_r[OTP_GATE_BIT]))
        else $error("otp pulse without enable");
    a_quad_needs_gate: assert property (periph_clk_en[CH_QUAD] |-> $past(gates_seen_r[QUAD_GATE_BIT]))
        else $error("quad pulse without enable");
    a_spi_needs_gate: assert property (periph_clk_en[CH_SPI] |-> $past(gates_seen_r[SPI_GATE_BIT]))
        else $error("spi pulse without enable");
    a_serial_aux_gates: assert property ((periph_clk_en[CH_UART1] |-> $past(gates_seen_r[FIRST_UART_GATE_BIT]))
        and (periph_clk_en[CH_UART2] |-> $past(gates_seen_r[SECOND_UART_GATE_BIT]))
        and (periph_clk_en[CH_I2C] |-> $past(gates_seen_r[I2C_GATE_BIT]))
        and (periph_clk_en[CH_WAKE] |-> $past(gates_seen_r[WAKE_GATE_BIT])))
        else $error("serial pulse without enable");
    a_timers_share_gate: assert property ((periph_clk_en[CH_FIRST_GENERAL_TIMER] || periph_clk_en[CH_THIRD_GENERAL_TIMER])
        |-> $past(gates_seen_r[TIMERS_GATE_BIT])) else $error("timer pulse without enable");
    a_baseband_needs_gate: assert property (periph_clk_en[CH_BASEBAND] |-> $past(radio_seen_r[BASEBAND_GATE_BIT]))
        else $error("baseband pulse without enable");
    a_rfcu_needs_gate: assert property (periph_clk_en[CH_RFCU] |-> $past(radio_seen_r[RFCU_GATE_BIT]))
        else $error("rf unit pulse without enable");
endmodule

bind cgd_clock_control cgd_clock_control_checker chk_u (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .source_clock_select(source_clock_select), .periph_clk_en(periph_clk_en),
    .crystal_coarse_trim(crystal_coarse_trim), .crystal_fine_trim(crystal_fine_trim),
    .baseband_lowpower_timer_reset(baseband_lowpower_timer_reset));

// [sim/cgd_periph_model.sv]
// on-chip clock consumers that count the enable pulses they receive
`timescale 1ns/1ps
module cgd_periph_model
    import cgd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic ahb_clk_en,
    input wire logic apb_clk_en,
    input wire logic [CGD_NUM_CH-1:0] periph_clk_en,
    input wire logic lp_timer_reset,
    output int ahb_cnt,
    output int apb_cnt,
    output int ch_cnt [CGD_NUM_CH],
    output int lp_ticks
);
    // ----------------------------------------------------------------
    // one step per pulse; an unknown pulse is not counted, so it shows
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (clr) begin
            ahb_cnt <= 0;
            apb_cnt <= 0;
            lp_ticks <= 0;
            foreach (ch_cnt[i]) ch_cnt[i] <= 0;
        end else begin
            ahb_cnt <= ahb_cnt + int'(ahb_clk_en === 1'b1);
            apb_cnt <= apb_cnt + int'(apb_clk_en === 1'b1);
            foreach (ch_cnt[i]) ch_cnt[i] <= ch_cnt[i] + int'(periph_clk_en[i] === 1'b1);
            // the low-power timer only advances once released from reset
            if (lp_timer_reset === 1'b0 && periph_clk_en[CH_BASEBAND] === 1'b1) lp_ticks <= lp_ticks + 1;
        end
    end
endmodule

// [sim/cgd_clock_control_tb_top.sv]
// self-checking testbench for the clock gating and divider control block
`timescale 1ns/1ps
module cgd_clock_control_tb_top
    import cgd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic slow_clk_pin = 1'b0;
    logic clr = 1'b0;
    cgd_bus_req_type bus_req = '0;
    logic [15:0] rd_data;
    logic [1:0] src_sel;
    logic ahb_en;
    logic apb_en;
    logic lp_rst;
    logic [CGD_NUM_CH-1:0] pen;
    logic [2:0] coarse;
    logic [7:0] fine;
    int ahb_cnt, apb_cnt, lp_ticks;
    int ch_cnt [CGD_NUM_CH];
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h2FF5;
    logic [15:0] got, g, r;
    logic [31:0] addrs [5] = '{BUS_DIV_ADDR, TRIM_ADDR, GATES_ADDR, RADIO_ADDR, 32'h5000_0006};
    logic [15:0] rstv [5] = '{16'h0022, 16'h0000, 16'h0000, 16'h0040, 16'h0000};
    logic [15:0] wmask [5] = '{16'h00B3, 16'h07FF, 16'h8BFB, 16'h00FB, 16'h0000};

    always #50 ref_clk = ~ref_clk;
    // slow source: one rising edge every 16 cycles
    always begin
        repeat (8) @(posedge ref_clk);
        slow_clk_pin <= ~slow_clk_pin;
    end

    cgd_clock_control dut_u (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
        .slow_clk_pin(slow_clk_pin), .source_clock_select(src_sel), .ahb_clk_en(ahb_en), .apb_clk_en(apb_en),
        .periph_clk_en(pen), .crystal_coarse_trim(coarse), .crystal_fine_trim(fine),
        .baseband_lowpower_timer_reset(lp_rst));
    cgd_periph_model model_u (.ref_clk(ref_clk), .clr(clr), .ahb_clk_en(ahb_en), .apb_clk_en(apb_en),
        .periph_clk_en(pen), .lp_timer_reset(lp_rst), .ahb_cnt(ahb_cnt), .apb_cnt(apb_cnt), .ch_cnt(ch_cnt),
        .lp_ticks(lp_ticks));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        samples_checked++;
        if (got_v !== exp_v) begin
            num_errors++;
            $display("unexpected at %0t: value %h expected %h", $time, got_v, exp_v);
        end
    endtask
    // divider phase at the window edges may add or drop one pulse; a stopped clock gives none
    task automatic chk_cnt(input int got_v, input int exp_v);
        samples_checked++;
        if (got_v < exp_v - 1 || got_v > exp_v + 1 || (exp_v == 0 && got_v != 0)) begin
            num_errors++;
            $display("unexpected at %0t: count %0d expected %0d", $time, got_v, exp_v);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        bus_req.wr_stb <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge ref_clk);
        bus_req.wr_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [31:0] a);
        bus_req.rd_stb <= 1'b1;
        bus_req.addr <= a;
        @(posedge ref_clk);
        bus_req.rd_stb <= 1'b0;
        #1 got = rd_data;
        @(posedge ref_clk);
    endtask
    // settle longer than the slowest old divider period, then count 256 cycles
    task automatic measure();
        repeat (100) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (256) @(posedge ref_clk);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i]);
            chk(got, rstv[i]);
        end
        // coarse trim kept at zero here: it may only move one step at a time
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 5; i++) begin
                seed = lfsr(seed);
                r = ((k == 0) ? 16'hFFFF : seed[15:0]) & ((i == 1) ? 16'hF8FF : 16'hFFFF);
                wr(addrs[i], r);
                rd(addrs[i]);
                chk(got, r & wmask[i]);
            end
        end
        for (int i = 0; i < 16; i++) begin
            wr(BUS_DIV_ADDR, {8'h00, i > 0, 1'b0, i[3:2], 2'b00, i[1:0]});
            measure();
            chk_cnt(ahb_cnt, 256 >> i[1:0]);
            chk_cnt(apb_cnt, 256 >> (int'(i[1:0]) + int'(i[3:2])));
            chk_cnt(ch_cnt[CH_OTP], (i > 0) ? 256 >> i[1:0] : 0);
        end
        wr(BUS_DIV_ADDR, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            g = (k == 0) ? 16'h8BFB : (k == 1) ? 16'h0000 : seed[15:0] & 16'h8BFB;
            g[9:8] = k[1:0];
            g[1:0] = ~k[1:0];
            wr(GATES_ADDR, g);
            measure();
            chk_cnt(ch_cnt[CH_QUAD], g[15] ? 256 : 0);
            chk_cnt(ch_cnt[CH_SPI], g[11] ? 256 >> g[9:8] : 0);
            chk_cnt(ch_cnt[CH_UART1], g[7] ? 256 : 0);
            chk_cnt(ch_cnt[CH_UART2], g[6] ? 256 : 0);
            chk_cnt(ch_cnt[CH_I2C], g[5] ? 256 : 0);
            chk_cnt(ch_cnt[CH_WAKE], g[4] ? 256 : 0);
            chk_cnt(ch_cnt[CH_FIRST_GENERAL_TIMER], g[3] ? 256 >> g[1:0] : 0);
            chk_cnt(ch_cnt[CH_THIRD_GENERAL_TIMER], g[3] ? 256 : 0);
        end
        // baseband stays at or above half the cpu rate and the rf unit at half the source
        for (int k = 0; k < 8; k++) begin
            r = {8'h00, k[0], k[1], 1'b0, k[2], k[0] ^ k[1], 1'b0, 2'h1};
            wr(RADIO_ADDR, r);
            measure();
            chk({15'h0000, lp_rst}, {15'h0000, r[6]});
            chk_cnt(ch_cnt[CH_BASEBAND], r[7] ? 256 >> r[4] : 0);
            chk_cnt(ch_cnt[CH_RFCU], r[3] ? 128 : 0);
            chk_cnt(lp_ticks, (r[7] && !r[6]) ? 256 >> r[4] : 0);
        end
        for (int k = 1; k < 5; k++) begin
            wr(SRC_SEL_ADDR, {14'h0000, k[1:0]});
            measure();
            chk({14'h0000, src_sel}, {14'h0000, k[1:0]});
            chk_cnt(ahb_cnt, k[1] ? 16 : 256);
            rd(SRC_SEL_ADDR);
            chk(got, {8'h00, k[1:0] == 2'h0, k[1:0] == 2'h1, k[1], 3'h0, k[1:0]});
        end
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            r = {5'h00, k[2:0], (k == 7) ? 8'hFF : seed[7:0]};
            wr(TRIM_ADDR, r);
            repeat (2000) @(posedge ref_clk);
            chk({5'h00, coarse, fine}, r);
        end
        do_reset();
        rd(RADIO_ADDR);
        chk(got, 16'h0040);
        final_report();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
endmodule
